// [hdl/ssce_pkg.sv]
// constants and types for the stream control and error flag register bank
// assumes a single 250 MHz clock and an axi4-lite register master

package ssce_pkg;

	// bus geometry
	localparam int          ADDR_W          = 8;              // byte address width on the register bus
	localparam int          DATA_W          = 32;             // register bus data width
	localparam int          REG_W           = 16;             // width of each documented register
	localparam int          WORD_W          = 10;             // one video word

	// register indices as printed, byte address is four times the index
	localparam logic [7:0]  IOCTL_IDX       = 8'h01;          // io processing control two
	localparam logic [7:0]  ERR_IDX         = 8'h02;          // stream one error flags
	localparam logic [7:0]  OUTCFG_IDX      = 8'h10;          // output configuration and input format view
	localparam logic [7:0]  IOCTL_ADDR      = IOCTL_IDX << 2;
	localparam logic [7:0]  ERR_ADDR        = ERR_IDX << 2;
	localparam logic [7:0]  OUTCFG_ADDR     = OUTCFG_IDX << 2;

	// control register field positions
	localparam int          PAYLOAD_REGEN_BIT = 10;           // payload id packet regeneration off
	localparam int          SWAP_BIT        = 9;              // stream swap
	localparam int          B2A_OFF_BIT     = 8;              // level b to a conversion off
	localparam int          ANC_SEL_BIT     = 7;              // ancillary extraction stream select
	localparam int          REMAP_OFF_BIT   = 4;              // stream two illegal word remap off
	localparam int          CKSUM_OFF_BIT   = 3;              // stream two checksum insertion off
	localparam int          CRC_OFF_BIT     = 2;              // stream two line crc insertion off
	localparam int          LNUM_OFF_BIT    = 1;              // stream two line number insertion off
	localparam int          TRS_OFF_BIT     = 0;              // stream two timing reference insertion off
	localparam logic [15:0] IOCTL_RST       = 16'h0100;       // only conversion-off set after reset
	localparam logic [15:0] IOCTL_RW_MASK   = 16'h079F;       // bits that hold state, the rest read zero

	// error register field positions
	localparam int          VSTD_ERR_BIT    = 10;
	localparam int          FULL_FIELD_CRC_ERROR_BIT  = 9;
	localparam int          ACTIVE_PICTURE_CRC_ERROR_BIT  = 8;
	localparam int          C_CKSUM_ERR_BIT = 6;
	localparam int          Y_CKSUM_ERR_BIT = 5;
	localparam int          C_LCRC_ERR_BIT  = 4;
	localparam int          Y_LCRC_ERR_BIT  = 3;
	localparam int          LNUM_ERR_BIT    = 2;
	localparam int          SAV_ERR_BIT     = 1;
	localparam int          EAV_ERR_BIT     = 0;
	localparam logic [15:0] ERR_RST         = 16'h0000;
	localparam logic [15:0] ERR_ALL_MASK    = 16'h077F;       // implemented flags
	localparam logic [15:0] ERR_NOT_SD_MASK = 16'h001C;       // line crc and line number flags
	localparam logic [15:0] ERR_HDSD_MASK   = 16'h0400;       // video standard flag

	// own output configuration register
	localparam int          TEN_BIT_BIT     = 0;              // 1 = 10-bit ddr output, 0 = 20-bit
	localparam int          FMT_LSB         = 4;              // read-only view of input format
	localparam logic [15:0] OUTCFG_RST      = 16'h0000;

	// input format codes
	localparam logic [1:0]  FMT_SD          = 2'h0;
	localparam logic [1:0]  FMT_HD          = 2'h1;
	localparam logic [1:0]  FMT_3GA         = 2'h2;
	localparam logic [1:0]  FMT_3GB         = 2'h3;

	// axi responses
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_SLVERR     = 2'h2;

	// output word phase, one-hot
	typedef enum logic [1:0] {
		PH_PAIR   = 2'b01,                                    // ready for a new pair
		PH_SECOND = 2'b10                                     // second ddr word pending
	} ssce_phase_type;

	// gated control outputs toward the video path
	typedef struct packed {
		logic b_to_a_conversion_en;
		logic anc_extract_stream_two;
		logic stream_two_remap_en;
		logic stream_two_checksum_insert_en;
		logic stream_two_crc_insert_en;
		logic stream_two_line_number_insert_en;
		logic stream_two_timing_ref_insert_en;
		logic payload_id_regen_en;
	} ssce_ctl_type;

	// whole module state
	typedef struct packed {
		logic                awready;
		logic                wready;
		logic                aw_held;
		logic                w_held;
		logic [ADDR_W-1:0]   awaddr;
		logic [DATA_W-1:0]   wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [DATA_W-1:0]   rdata;
		logic [1:0]          rresp;
		logic [REG_W-1:0]    ioctl;
		logic [REG_W-1:0]    err;
		logic [REG_W-1:0]    outcfg;
		ssce_phase_type      phase;
		logic [WORD_W-1:0]   pending;
		logic [2*WORD_W-1:0] dout;
		logic                dout_valid;
		logic                in_ready;
		ssce_ctl_type        ctl;
	} ssce_state_type;

endpackage

// [hdl/ssce_top.sv]
// stream control and stream one error flag register bank of a serial video receiver
// assumes axi4-lite master on aclk, video words and error pulses synchronous to aclk
//
// Implementation choice: register access over AXI4-Lite.

`timescale 1ns/100ps

// Overview of operation
// [RULE1] swap clear, 20-bit: stream one on upper
// [RULE2] swap set, 20-bit: stream two on upper
// [RULE3] ddr, swap clear: stream two word first
// [RULE4] ddr, swap set: stream one word first
// [RULE5] conversion-off bit resets one, level b only
// [RULE6] bit 7 picks anc stream, level b
// [RULE7] select zero stream one, one stream two
// [RULE8] bit 4 stops stream two remap
// [RULE9] bit 3 stops stream two checksum insertion
// [RULE10] bit 2 stops stream two crc insertion
// [RULE11] bit 1 stops stream two line numbers
// [RULE12] bit 0 stops stream two timing refs
// [RULE13] bit 10 video standard error, hd/sd
// [RULE14] bit 9 full-field crc failure
// [RULE15] bit 8 active-picture crc failure
// [RULE16] bits 6,5 chroma/luma checksum errors
// [RULE17] bits 4,3 line crc, not sd
// [RULE18] bit 2 line number error, not sd
// [RULE19] bit 1 sav, bit 0 eav errors
// [RULE20] flags sticky, read-only, write clears, reset zero
// [RULE21] software enables regen only with conversion
module ssce_top (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	// axi4-lite write address
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [ssce_pkg::ADDR_W-1:0]       s_axi_awaddr,
	input  wire logic [2:0]                        s_axi_awprot,
	// axi4-lite write data
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	input  wire logic [ssce_pkg::DATA_W-1:0]       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	// axi4-lite write response
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	output logic [1:0]                             s_axi_bresp,
	// axi4-lite read address
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	input  wire logic [ssce_pkg::ADDR_W-1:0]       s_axi_araddr,
	input  wire logic [2:0]                        s_axi_arprot,
	// axi4-lite read data
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	output logic [ssce_pkg::DATA_W-1:0]            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	// video input pair and detected format
	input  wire logic [1:0]                        input_format,
	input  wire logic                              in_valid,
	output logic                                   in_ready,
	input  wire logic [ssce_pkg::WORD_W-1:0]       stream_one_word,
	input  wire logic [ssce_pkg::WORD_W-1:0]       stream_two_word,
	// stream one error event pulses, bit positions as in the error register
	input  wire logic [ssce_pkg::REG_W-1:0]        err_event,
	// parallel output
	output logic [2*ssce_pkg::WORD_W-1:0]          dout,
	output logic                                   dout_valid,
	// gated controls toward the processing path
	output ssce_pkg::ssce_ctl_type                 ctl
);
	import ssce_pkg::*;

	// current and next state
	ssce_state_type s_ff;
	ssce_state_type nxt_s;

	// state after reset
	localparam ssce_state_type RST_STATE = '{
		awready : 1'b1,
		wready  : 1'b1,
		aw_held : 1'b0,
		w_held  : 1'b0,
		awaddr  : '0,
		wdata   : '0,
		wstrb   : '0,
		bvalid  : 1'b0,
		bresp   : RESP_OKAY,
		arready : 1'b1,
		rvalid  : 1'b0,
		rdata   : '0,
		rresp   : RESP_OKAY,
		ioctl   : IOCTL_RST,
		err     : ERR_RST,
		outcfg  : OUTCFG_RST,
		phase   : PH_PAIR,
		pending : '0,
		dout    : '0,
		dout_valid : 1'b0,
		in_ready   : 1'b1,
		ctl        : '0
	};

	// merges a 16-bit register with the low two byte lanes of a write
	function automatic logic [REG_W-1:0] merge_lanes(
		input logic [REG_W-1:0]  old_val,
		input logic [DATA_W-1:0] data,
		input logic [3:0]        strb
	);
		logic [REG_W-1:0] r;
		r = old_val;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		return r;
	endfunction

	// true when the byte address hits one of the mapped registers
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == IOCTL_ADDR) || (a == ERR_ADDR) || (a == OUTCFG_ADDR);
	endfunction

	// which error flags may be raised for a given input format
	function automatic logic [REG_W-1:0] err_allowed(input logic [1:0] fmt);
		logic [REG_W-1:0] m;
		m = ERR_ALL_MASK;
		if (fmt == FMT_SD) begin
			m = m & ~ERR_NOT_SD_MASK;                           // [RULE17] [RULE18]
		end
		if ((fmt != FMT_SD) && (fmt != FMT_HD)) begin
			m = m & ~ERR_HDSD_MASK;                             // [RULE13]
		end
		return m;
	endfunction

	// next-state logic
	always_comb begin
		logic             wr_fire;
		logic             err_clear;
		logic             level_b;
		logic             swap;
		logic             ddr;
		logic [REG_W-1:0] rd_val;
		wr_fire   = 1'b0;
		err_clear = 1'b0;
		level_b   = 1'b0;
		swap      = 1'b0;
		ddr       = 1'b0;
		rd_val    = '0;
		nxt_s     = s_ff;

		// write address and data taken in either order
		if (s_axi_awvalid && s_ff.awready) begin
			nxt_s.aw_held = 1'b1;
			nxt_s.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_ff.wready) begin
			nxt_s.w_held = 1'b1;
			nxt_s.wdata  = s_axi_wdata;
			nxt_s.wstrb  = s_axi_wstrb;
		end

		// both halves held: perform the write and answer
		if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
			wr_fire       = 1'b1;
			nxt_s.aw_held = 1'b0;
			nxt_s.w_held  = 1'b0;
			nxt_s.bvalid  = 1'b1;
			nxt_s.bresp   = addr_mapped(s_ff.awaddr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (s_ff.bvalid && s_axi_bready) begin
			nxt_s.bvalid = 1'b0;
		end

		// register updates, reserved bits stay zero
		if (wr_fire) begin
			case (s_ff.awaddr)
				IOCTL_ADDR: begin
					nxt_s.ioctl = merge_lanes(s_ff.ioctl, s_ff.wdata, s_ff.wstrb) & IOCTL_RW_MASK;
				end
				ERR_ADDR: begin
					err_clear = 1'b1;                              // [RULE20]
				end
				OUTCFG_ADDR: begin
					nxt_s.outcfg[TEN_BIT_BIT] = s_ff.wstrb[0] ? s_ff.wdata[TEN_BIT_BIT] : s_ff.outcfg[TEN_BIT_BIT];
				end
				default: begin
					nxt_s.ioctl = s_ff.ioctl;                      // unmapped, nothing stored
				end
			endcase
		end

		// sticky error flags, a new event wins over a clear
		nxt_s.err = ((err_clear ? ERR_RST : s_ff.err)
			| (err_event & err_allowed(input_format))) & ERR_ALL_MASK;   // [RULE13] [RULE14] [RULE15] [RULE16] [RULE17] [RULE18] [RULE19] [RULE20]

		// read channel, data sampled when the address is taken
		case (s_axi_araddr)
			IOCTL_ADDR: begin
				rd_val = s_ff.ioctl;
			end
			ERR_ADDR: begin
				rd_val = s_ff.err;                                 // [RULE20]
			end
			OUTCFG_ADDR: begin
				rd_val = s_ff.outcfg;
				rd_val[FMT_LSB+1:FMT_LSB] = input_format;
			end
			default: begin
				rd_val = '0;
			end
		endcase
		if (s_axi_arvalid && s_ff.arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata  = {16'h0000, rd_val};
			nxt_s.rresp  = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_ff.rvalid && s_axi_rready) begin
			nxt_s.rvalid = 1'b0;
		end

		// ready flags registered so the ports come from flip-flops
		nxt_s.awready = !nxt_s.aw_held && !nxt_s.bvalid;
		nxt_s.wready  = !nxt_s.w_held && !nxt_s.bvalid;
		nxt_s.arready = !nxt_s.rvalid;

		// output word placement
		swap = s_ff.ioctl[SWAP_BIT];
		ddr  = s_ff.outcfg[TEN_BIT_BIT];
		nxt_s.dout_valid = 1'b0;
		case (s_ff.phase)
			PH_PAIR: begin
				if (in_valid) begin
					nxt_s.dout_valid = 1'b1;
					if (!ddr) begin
						// 20-bit: both streams side by side
						nxt_s.dout = swap ? {stream_two_word, stream_one_word}   // [RULE2]
							: {stream_one_word, stream_two_word};                // [RULE1]
					end else begin
						// 10-bit: first word now, second next cycle
						nxt_s.dout    = {10'h000, swap ? stream_one_word : stream_two_word};  // [RULE3] [RULE4]
						nxt_s.pending = swap ? stream_two_word : stream_one_word;             // [RULE3] [RULE4]
						nxt_s.phase   = PH_SECOND;
					end
				end
			end
			PH_SECOND: begin
				// second word of the pair, no new pair taken
				nxt_s.dout_valid = 1'b1;
				nxt_s.dout       = {10'h000, s_ff.pending};
				nxt_s.phase      = PH_PAIR;
			end
			default: begin
				nxt_s.phase = PH_PAIR;
			end
		endcase
		// a pair is accepted only in the pair phase
		nxt_s.in_ready = (nxt_s.phase == PH_PAIR);

		// controls toward the processing path, active for level b only
		level_b = (input_format == FMT_3GB);
		nxt_s.ctl.b_to_a_conversion_en             = level_b && !s_ff.ioctl[B2A_OFF_BIT];        // [RULE5]
		nxt_s.ctl.anc_extract_stream_two           = level_b && s_ff.ioctl[ANC_SEL_BIT];         // [RULE6] [RULE7]
		nxt_s.ctl.stream_two_remap_en              = level_b && !s_ff.ioctl[REMAP_OFF_BIT];      // [RULE8]
		nxt_s.ctl.stream_two_checksum_insert_en    = level_b && !s_ff.ioctl[CKSUM_OFF_BIT];      // [RULE9]
		nxt_s.ctl.stream_two_crc_insert_en         = level_b && !s_ff.ioctl[CRC_OFF_BIT];        // [RULE10]
		nxt_s.ctl.stream_two_line_number_insert_en = level_b && !s_ff.ioctl[LNUM_OFF_BIT];       // [RULE11]
		nxt_s.ctl.stream_two_timing_ref_insert_en  = level_b && !s_ff.ioctl[TRS_OFF_BIT];        // [RULE12]
		// regeneration follows its own bit; software pairs it with conversion
		nxt_s.ctl.payload_id_regen_en              = level_b && !s_ff.ioctl[PAYLOAD_REGEN_BIT];  // [RULE21]
	end

	// single state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= RST_STATE;                                 // [RULE5] [RULE6] [RULE20]
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ports straight from the state register
	assign s_axi_awready = s_ff.awready;
	assign s_axi_wready  = s_ff.wready;
	assign s_axi_bvalid  = s_ff.bvalid;
	assign s_axi_bresp   = s_ff.bresp;
	assign s_axi_arready = s_ff.arready;
	assign s_axi_rvalid  = s_ff.rvalid;
	assign s_axi_rdata   = s_ff.rdata;
	assign s_axi_rresp   = s_ff.rresp;
	assign in_ready      = s_ff.in_ready;
	assign dout          = s_ff.dout;
	assign dout_valid    = s_ff.dout_valid;
	assign ctl           = s_ff.ctl;

endmodule

// [verif/ssce_sink.sv]
// downstream sink model for the parallel video output
// assumes dout and dout_valid are registered on aclk
`timescale 1ns/100ps
module ssce_sink (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [19:0] dout,
	input  wire logic        dout_valid
);
	logic [19:0] got [$];             // words in arrival order

	// keep every flagged word, as the video path would
	always @(posedge aclk) begin
		if (aresetn && dout_valid) begin
			got.push_back(dout);
		end
	end
endmodule

// [verif/ssce_checker.sv]
// port checker for the stream control and error flag bank
// assumes it is bound onto ssce_top and sees its ports only
`timescale 1ns/100ps
module ssce_checker
	import ssce_pkg::*;
(
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic         s_axi_arvalid,
	input  wire logic         s_axi_arready,
	input  wire logic         s_axi_rvalid,
	input  wire logic         s_axi_rready,
	input  wire logic [31:0]  s_axi_rdata,
	input  wire logic [1:0]   input_format,
	input  wire logic         in_valid,
	input  wire logic         in_ready,
	input  wire logic [19:0]  dout,
	input  wire logic         dout_valid,
	input  ssce_pkg::ssce_ctl_type ctl
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// every controlled path is off unless level b input
	property p_ctl_gate; input_format != 2'h3 |=> ctl == '0; endproperty
	a_ctl_gate: assert property (p_ctl_gate) else $error("control active off level b");
	// accepted pair shows one cycle later
	property p_dout_lat; in_valid && in_ready |=> dout_valid; endproperty
	a_dout_lat: assert property (p_dout_lat) else $error("no output word after pair");
	// ddr first word sits on the low half only
	property p_ddr_upper; !in_ready |-> dout_valid && dout[19:10] == 10'h000; endproperty
	a_ddr_upper: assert property (p_ddr_upper) else $error("ddr word upper half not zero");
	// ddr second word follows at once
	property p_ddr_second; !in_ready |=> dout_valid && in_ready; endproperty
	a_ddr_second: assert property (p_ddr_second) else $error("ddr second word missing");
	// read answer the edge after the address
	property p_rvalid; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read answer late");
	// read data stands until taken
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	// no second read while one is pending
	property p_arblock; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arblock: assert property (p_arblock) else $error("read address taken while busy");
	// write response stands until taken
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
endmodule

bind ssce_top ssce_checker ssce_checker_inst (.*);

// [verif/sdi_stream_control_and_errors_tb.sv]
// self-checking bench for the stream control and error flag bank
// assumes ssce_top, the sink model and the bound checker
`timescale 1ns/100ps
module sdi_stream_control_and_errors_tb;
	import ssce_pkg::*;
	typedef struct {
		logic        ddr;
		logic        swap;
		logic [19:0] e1;
		logic [19:0] e2;
	} ssce_row_type;                  // one output ordering case
	localparam logic [9:0] S1 = 10'h2A5;
	localparam logic [9:0] S2 = 10'h15A;
	logic         aclk, aresetn;
	logic         awvalid, wvalid, bready, arvalid, rready, in_valid;
	logic         awready, wready, bvalid, arready, rvalid, in_ready, dout_valid;
	logic [7:0]   awaddr, araddr;
	logic [31:0]  wdata, rdata, rd_val;
	logic [1:0]   bresp, rresp, fmt, resp;
	logic [15:0]  ev, exp_err;
	logic [19:0]  dout;
	ssce_ctl_type ctl;
	ssce_row_type rows [4];
	int           bad_count = 0;
	int           checks = 0;
	int           cyc = 0;

	ssce_top ssce_top_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.input_format(fmt), .in_valid(in_valid), .in_ready(in_ready),
		.stream_one_word(S1), .stream_two_word(S2), .err_event(ev),
		.dout(dout), .dout_valid(dout_valid), .ctl(ctl));
	ssce_sink ssce_sink_inst (.aclk(aclk), .aresetn(aresetn), .dout(dout), .dout_valid(dout_valid));

	// 250 mhz clock
	always #2 aclk = ~aclk;

	// hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			end_sim();
		end
	end

	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// axi4-lite write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (!bvalid);
		resp = bresp;
		bready <= 1'h0;
	endtask

	// axi4-lite read
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (!rvalid);
		rd_val = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask

	// counts then verdict
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		aclk = 1'h0;
		aresetn = 1'h0;
		{awvalid, wvalid, bready, arvalid, rready, in_valid} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		ev = '0;
		fmt = 2'h3;
		rows[0] = '{1'h0, 1'h0, {S1, S2}, {S1, S2}};
		rows[1] = '{1'h0, 1'h1, {S2, S1}, {S2, S1}};
		rows[2] = '{1'h1, 1'h0, {10'h000, S2}, {10'h000, S1}};
		rows[3] = '{1'h1, 1'h1, {10'h000, S1}, {10'h000, S2}};
		repeat (16) @(posedge aclk);
		aresetn <= 1'h1;
		// reset values and an unmapped place
		rd(IOCTL_ADDR);
		chk(rd_val, 32'h0000_0100);
		chk(32'(resp), 32'(RESP_OKAY));
		rd(ERR_ADDR);
		chk(rd_val, 32'h0);
		chk(32'(ctl), 32'h3F);
		rd(8'h0C);
		chk(32'(resp), 32'(RESP_SLVERR));
		chk(rd_val, 32'h0);
		wr(8'h0C, 32'hFFFF);
		chk(32'(resp), 32'(RESP_SLVERR));
		$display("reset test done");
		// output ordering table
		foreach (rows[i]) begin
			wr(IOCTL_ADDR, {22'h0, rows[i].swap, 9'h100});
			wr(OUTCFG_ADDR, {31'h0, rows[i].ddr});
			ssce_sink_inst.got.delete();
			@(posedge aclk);
			in_valid <= 1'h1;
			do @(posedge aclk); while (!in_ready);
			in_valid <= 1'h0;
			repeat (3) @(posedge aclk);
			chk(32'(ssce_sink_inst.got.size()), 32'(rows[i].ddr) + 32'h1);
			chk(32'(ssce_sink_inst.got[0]), 32'(rows[i].e1));
			if (rows[i].ddr) chk(32'(ssce_sink_inst.got[1]), 32'(rows[i].e2));
			$display("row %0d done", i);
		end
		// output configuration reads back ddr bit and the level b format view
		rd(OUTCFG_ADDR);
		chk(rd_val, 32'h0000_0031);
		chk(32'(resp), 32'(RESP_OKAY));
		// each stream two mask alone
		for (int i = 0; i < 5; i++) begin
			wr(IOCTL_ADDR, 32'h100 | (32'h1 << i));
			chk(32'(resp), 32'(RESP_OKAY));
			repeat (2) @(posedge aclk);
			chk(32'(ctl), 32'h3F ^ (32'h2 << i));
		end
		wr(IOCTL_ADDR, 32'h0000_0080);
		repeat (2) @(posedge aclk);
		chk(32'(ctl), 32'hFF);
		fmt <= 2'h2;
		repeat (2) @(posedge aclk);
		chk(32'(ctl), 32'h0);
		$display("control test done");
		// error flags per input format, then clear
		for (int f = 0; f < 4; f++) begin
			fmt <= 2'(f);
			ev <= ERR_ALL_MASK;
			exp_err = ERR_ALL_MASK & ~(f == 0 ? ERR_NOT_SD_MASK : 16'h0) & ~(f > 1 ? ERR_HDSD_MASK : 16'h0);
			@(posedge aclk);
			ev <= 16'h0;
			rd(ERR_ADDR);
			chk(rd_val, {16'h0, exp_err});
			wr(ERR_ADDR, 32'hFFFF);
			rd(ERR_ADDR);
			chk(rd_val, 32'h0);
		end
		$display("error test done");
		end_sim();
	end
endmodule
